// ==== tcc_pkg.sv ====
package tcc_pkg;
    // Machine cycle: six oscillator periods, taken as six mclk cycles
    localparam int unsigned MCYC_LEN = 6;
    localparam logic [2:0] MCYC_LAST = 3'h5;
    localparam logic [2:0] MCYC_ZERO = 3'h0;
    // Channel count and count width
    localparam int unsigned NCH = 4;
    localparam int unsigned CW = 16;
    localparam logic [15:0] CNT_RST = 16'h0000;
    localparam logic [15:0] CNT_ONES = 16'hFFFF;
    localparam logic [15:0] CNT_ONE = 16'h0001;

    // Count input selection
    typedef enum logic [1:0] {
        TCC_STOP = 2'h0,
        TCC_TIMER = 2'h1,
        TCC_COUNTER = 2'h2,
        TCC_GATED = 2'h3
    } tcc_cmode_t;

    // Per-channel function
    typedef enum logic [1:0] {
        TCC_CH_OFF = 2'h0,
        TCC_CH_CMP = 2'h1,
        TCC_CH_CAP = 2'h2
    } tcc_chfn_t;

    // Configuration bits, plain ports
    typedef struct packed {
        tcc_cmode_t count_mode;
        logic presc_div12;        // 1: count every second machine cycle
        logic reload_en;
        logic reload_mode1;       // 0: on overflow, 1: on trigger pin fall
        logic external_trigger_enable;
        logic [3:0] ch_cmp_mode1; // Per channel compare mode 1
        logic [3:0] ch_cap_rise;  // Per channel capture edge, 1 rising
    } tcc_cfg_t;

    // Event flags, each a one-cycle pulse
    typedef struct packed {
        logic timer_overflow_flag;
        logic external_trigger_flag;
        logic [3:0] ch_req;
    } tcc_evt_t;
endpackage : tcc_pkg

// ==== tcc_sync.sv ====
`timescale 1ns/10ps
`default_nettype none
// Two-flop synchroniser for a vector of pins
module tcc_sync #(
    parameter int unsigned W = 1
) (
    // Clock and reset
    input wire logic mclk,
    input wire logic rst_b,
    // Data
    input wire logic [W-1:0] d,
    output logic [W-1:0] q
);
    logic [W-1:0] meta_ff;

    // First stage feeds only the second
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            meta_ff <= '0;
            q <= '0;
        end else begin
            meta_ff <= d;
            q <= meta_ff;
        end
    end
endmodule : tcc_sync
`default_nettype wire

// ==== tcc_top.sv ====
// How it works
// - 16-bit count; rollover from all ones to zero pulses overflow flag.
// - Timer mode counts every machine cycle or every second one.
// - Gated mode counts only while gate pin is high.
// - Gate pin sampled once per machine cycle.
// - Event mode counts a falling edge seen across two machine samples.
// - Reload mode 0 loads reload value on rollover and flags overflow.
// - Reload mode 1 loads reload value on trigger pin falling edge.
// - Trigger fall sets external trigger flag only when enabled.
// - Enabled compare channel matching count pulses its request.
// - Compare mode 0 output rises on match, falls on overflow.
// - Compare mode 0 ignores software writes to the output bit.
// - Compare mode 1 writes go to shadow, copied out on match.
// - Mode 1 match toggles output only when shadow differs.
// - Four compare outputs and four capture inputs.
`timescale 1ns/10ps
`default_nettype none
module tcc_top (
    // Clock and reset
    input wire logic mclk,
    input wire logic rst_b,
    // Configuration
    input wire tcc_pkg::tcc_cfg_t cfg,
    input wire tcc_pkg::tcc_chfn_t [3:0] ch_fn,
    input wire logic [15:0] reload_value,
    input wire logic [3:0][15:0] cmp_value,
    // Software port write into channel output bits
    input wire logic [3:0] port_wr,
    input wire logic [3:0] port_wdata,
    // Pins
    input wire logic gate_event_input_pin,
    input wire logic reload_trigger_pin,
    input wire logic [3:0] cap_pin,
    output logic [3:0] cmp_pin,
    // Status
    output logic [15:0] count,
    output logic [3:0][15:0] cap_value,
    output tcc_pkg::tcc_evt_t evt
);
    import tcc_pkg::*;

    logic rst_meta_ff;
    logic rst_sync_ff;
    logic [5:0] pin_s;
    logic [2:0] mcyc_ff;
    logic [2:0] nxt_mcyc;
    logic half_ff;
    logic gate_smp_ff;
    logic gate_prev_ff;
    logic trig_smp_ff;
    logic trig_prev_ff;
    logic [3:0] cap_prev_ff;
    logic [15:0] cnt_ff;
    logic [15:0] nxt_cnt;
    logic [3:0] out_ff;
    logic [3:0] shadow_ff;

    // Reset released through two flops, asserted at once
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            rst_meta_ff <= 1'b0;
            rst_sync_ff <= 1'b0;
        end else begin
            rst_meta_ff <= 1'b1;
            rst_sync_ff <= rst_meta_ff;
        end
    end

    // Pins cross into mclk before any logic looks at them
    tcc_sync #(.W(6)) u_sync (
        .mclk(mclk),
        .rst_b(rst_sync_ff),
        .d({cap_pin, reload_trigger_pin, gate_event_input_pin}),
        .q(pin_s)
    );

    // Machine cycle strobe and prescaler phase
    wire mcyc_end = (mcyc_ff == MCYC_LAST);
    assign nxt_mcyc = mcyc_end ? MCYC_ZERO : mcyc_ff + 3'h1;
    always_ff @(posedge mclk or negedge rst_sync_ff) begin
        if (!rst_sync_ff) begin
            mcyc_ff <= MCYC_ZERO;
            half_ff <= 1'b0;
        end else begin
            mcyc_ff <= nxt_mcyc;
            if (mcyc_end)
                half_ff <= ~half_ff;
        end
    end

    // Pin samples taken once per machine cycle
    // Reset low like the synchroniser, so an idle-low pin fakes no fall
    always_ff @(posedge mclk or negedge rst_sync_ff) begin
        if (!rst_sync_ff) begin
            gate_smp_ff <= 1'b0;
            gate_prev_ff <= 1'b0;
            trig_smp_ff <= 1'b0;
            trig_prev_ff <= 1'b0;
        end else if (mcyc_end) begin
            gate_smp_ff <= pin_s[0];
            gate_prev_ff <= gate_smp_ff;
            trig_smp_ff <= pin_s[1];
            trig_prev_ff <= trig_smp_ff;
        end
    end

    // Count enables, decoded per machine cycle
    // Event edge needs two samples, so peak rate is half the machine rate
    wire rate_ok = ~cfg.presc_div12 | half_ff;
    wire tick_timer = mcyc_end & rate_ok & (cfg.count_mode == TCC_TIMER);
    wire tick_gated = mcyc_end & rate_ok & gate_smp_ff
                      & (cfg.count_mode == TCC_GATED);
    wire tick_event = mcyc_end & gate_prev_ff & ~gate_smp_ff
                      & (cfg.count_mode == TCC_COUNTER);
    wire tick = tick_timer | tick_gated | tick_event;
    wire ovf = tick & (cnt_ff == CNT_ONES);
    wire trig_fall = mcyc_end & trig_prev_ff & ~trig_smp_ff;
    wire ld_ovf = ovf & cfg.reload_en & ~cfg.reload_mode1;
    wire ld_trig = trig_fall & cfg.reload_en & cfg.reload_mode1;

    // Trigger load wins over a simultaneous count step
    assign nxt_cnt = (ld_trig | ld_ovf) ? reload_value
                   : tick ? cnt_ff + CNT_ONE : cnt_ff;

    always_ff @(posedge mclk or negedge rst_sync_ff) begin
        if (!rst_sync_ff)
            cnt_ff <= CNT_RST;
        else
            cnt_ff <= nxt_cnt;
    end

    // Per-channel compare and capture, all four alike
    logic [3:0] match;
    logic [3:0] cap_hit;
    logic [3:0] nxt_out;
    genvar g;
    generate
        for (g = 0; g < NCH; g++) begin : g_ch
            wire is_cmp = (ch_fn[g] == TCC_CH_CMP);
            wire is_cap = (ch_fn[g] == TCC_CH_CAP);
            // Match only on the cycle the count changes, so a held
            // value fires once per pass
            assign match[g] = is_cmp & tick & (nxt_cnt == cmp_value[g]);
            wire fall = cap_prev_ff[g] & ~pin_s[2+g];
            wire rise = ~cap_prev_ff[g] & pin_s[2+g];
            assign cap_hit[g] = is_cap & (cfg.ch_cap_rise[g] ? rise : fall);
            // Mode 0: match sets, overflow clears; match wins a tie
            wire m0 = match[g] ? 1'b1 : ovf ? 1'b0 : out_ff[g];
            // Mode 1: shadow copied on match, identical level stays put
            wire m1 = match[g] ? shadow_ff[g] : out_ff[g];
            assign nxt_out[g] = ~is_cmp ? out_ff[g]
                              : cfg.ch_cmp_mode1[g] ? m1 : m0;

            always_ff @(posedge mclk or negedge rst_sync_ff) begin
                if (!rst_sync_ff)
                    cap_value[g] <= CNT_RST;
                else if (cap_hit[g])
                    cap_value[g] <= cnt_ff;
            end
        end
    endgenerate

    // Shadow latch takes software writes in either mode; mode 0 output ignores it
    always_ff @(posedge mclk or negedge rst_sync_ff) begin
        if (!rst_sync_ff) begin
            shadow_ff <= '0;
            out_ff <= '0;
            // Matches synchroniser reset; an idle-high pin still shows one
            // rise after reset, so enable rising capture once pins settle
            cap_prev_ff <= '0;
        end else begin
            for (int i = 0; i < NCH; i++) begin
                if (port_wr[i])
                    shadow_ff[i] <= port_wdata[i];
            end
            out_ff <= nxt_out;
            cap_prev_ff <= pin_s[5:2];
        end
    end

    // Registered outputs
    always_ff @(posedge mclk or negedge rst_sync_ff) begin
        if (!rst_sync_ff) begin
            evt <= '0;
        end else begin
            evt.timer_overflow_flag <= ovf;
            evt.external_trigger_flag <= trig_fall & cfg.external_trigger_enable;
            evt.ch_req <= match | cap_hit;
        end
    end
    assign cmp_pin = out_ff;
    assign count = cnt_ff;

    // Checks
    a_ovf_wrap: assert property (@(posedge mclk) disable iff (!rst_sync_ff)
        ovf |=> evt.timer_overflow_flag
            && (count == CNT_RST || $past(ld_ovf) || $past(ld_trig)))
        else $error("overflow flag or wrap missing");
    a_reload_ovf: assert property (@(posedge mclk) disable iff (!rst_sync_ff)
        ld_ovf && !ld_trig |=> count == $past(reload_value))
        else $error("overflow reload wrong");
    a_reload_trig: assert property (@(posedge mclk) disable iff (!rst_sync_ff)
        ld_trig |=> count == $past(reload_value))
        else $error("trigger reload wrong");
    a_trig_flag: assert property (@(posedge mclk) disable iff (!rst_sync_ff)
        evt.external_trigger_flag |-> $past(cfg.external_trigger_enable))
        else $error("trigger flag while disabled");
    a_gate_hold: assert property (@(posedge mclk) disable iff (!rst_sync_ff)
        cfg.count_mode == TCC_GATED && !gate_smp_ff && !ld_trig |=> $stable(count))
        else $error("gated count moved");
    a_mcyc_only: assert property (@(posedge mclk) disable iff (!rst_sync_ff)
        !mcyc_end && !ld_trig |=> $stable(count))
        else $error("count moved mid machine cycle");
    // Event step: a high sample, then a low one, then exactly one count more
    sequence s_evt_fall;
        mcyc_end && gate_prev_ff && !gate_smp_ff && cfg.count_mode == TCC_COUNTER;
    endsequence
    sequence s_no_load;
        !ld_ovf && !ld_trig;
    endsequence
    a_event_step: assert property (@(posedge mclk) disable iff (!rst_sync_ff)
        s_evt_fall ##0 s_no_load |=> count == $past(count) + CNT_ONE)
        else $error("event edge not counted");
    a_cmp0_rise: assert property (@(posedge mclk) disable iff (!rst_sync_ff)
        match[0] && !cfg.ch_cmp_mode1[0] |=> cmp_pin[0])
        else $error("mode 0 output not high");
    a_cmp0_fall: assert property (@(posedge mclk) disable iff (!rst_sync_ff)
        ovf && !match[0] && ch_fn[0] == TCC_CH_CMP && !cfg.ch_cmp_mode1[0]
        |=> !cmp_pin[0])
        else $error("mode 0 output not cleared by overflow");
    a_mode0_write: assert property (@(posedge mclk) disable iff (!rst_sync_ff)
        port_wr[0] && ch_fn[0] == TCC_CH_CMP && !cfg.ch_cmp_mode1[0] && !match[0] && !ovf
        |=> $stable(cmp_pin[0]))
        else $error("mode 0 output moved on a port write");
    a_cmp1_copy: assert property (@(posedge mclk) disable iff (!rst_sync_ff)
        match[1] && cfg.ch_cmp_mode1[1] |=> cmp_pin[1] == $past(shadow_ff[1]))
        else $error("mode 1 shadow not copied");
    a_cap_copy: assert property (@(posedge mclk) disable iff (!rst_sync_ff)
        cap_hit[2] |=> cap_value[2] == $past(count))
        else $error("capture value wrong");
endmodule : tcc_top
`default_nettype wire

// ==== tcc_pins.sv ====
`timescale 1ns/10ps
`default_nettype none
// Pin-side model; pins change only just after a rising edge
module tcc_pins (
    // Clock
    input wire logic mclk,
    // Pins toward the timer
    output logic gate_event_input_pin,
    output logic reload_trigger_pin,
    output logic [3:0] cap_pin
);
    // Idle levels from time zero; trigger idles high so a fall is an event
    initial begin
        gate_event_input_pin = 1'h0;
        reload_trigger_pin = 1'h1;
        cap_pin = 4'h0;
    end
    // Pin 0 gate/event, 1 trigger, 2 to 5 capture; level held h cycles
    task automatic set_pin(input int k, input logic v, input int h);
        @(posedge mclk);
        if (k == 0) gate_event_input_pin <= v;
        else if (k == 1) reload_trigger_pin <= v;
        else cap_pin[k-2] <= v;
        repeat (h) @(posedge mclk);
    endtask : set_pin
endmodule : tcc_pins
`default_nettype wire

// ==== tcc_top_bench.sv ====
`timescale 1ns/10ps
`default_nettype none
module tcc_top_bench;
    import tcc_pkg::*;
    logic mclk, rst_b, gpin, tpin;
    tcc_cfg_t cfg;
    tcc_chfn_t [3:0] ch_fn;
    logic [15:0] rld, count;
    logic [3:0][15:0] cmpv, capv;
    logic [3:0] pwr, pwd, cpin, cmp_pin;
    tcc_evt_t evt;
    int fail_count = 0;
    int samples_checked = 0;
    int ovf_n, trg_n, req_n, cap_n;
    // Device and its pin-side model
    tcc_top u_dut (.mclk(mclk), .rst_b(rst_b), .cfg(cfg), .ch_fn(ch_fn),
        .reload_value(rld), .cmp_value(cmpv), .port_wr(pwr), .port_wdata(pwd),
        .gate_event_input_pin(gpin), .reload_trigger_pin(tpin), .cap_pin(cpin),
        .cmp_pin(cmp_pin), .count(count), .cap_value(capv), .evt(evt));
    tcc_pins u_pins (.mclk(mclk), .gate_event_input_pin(gpin),
        .reload_trigger_pin(tpin), .cap_pin(cpin));
    // Clock, 10 ns period
    initial begin
        mclk = 1'h0;
        forever #5 mclk = ~mclk;
    end
    // Pulses tallied at the falling edge, where they have settled
    always @(negedge mclk) begin
        ovf_n += int'(evt.timer_overflow_flag);
        trg_n += int'(evt.external_trigger_flag);
        req_n += int'(evt.ch_req[0]);
        cap_n += int'(evt.ch_req[2]);
    end
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            fail_count++;
            $display("ERROR %0t: got %h, want %h", $time, seen, exp);
        end
    endtask : check
    task automatic results();
        $display("Checked %0d, failed %0d", samples_checked, fail_count);
        if (fail_count == 0 && samples_checked > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask : results
    // Bounded wait for a count value; a miss shows up in the compare
    task automatic wait_cnt(input logic [15:0] v, input int lim);
        for (int n = 0; n < lim && count !== v; n++) @(negedge mclk);
        check(count, v);
    endtask : wait_cnt
    // Second interval between count steps; the first may be cut short
    task automatic rate(input logic [15:0] exp);
        logic [15:0] c;
        logic [15:0] n;
        repeat (2) begin
            c = count;
            for (n = 16'h0000; count === c && n < 16'h0028; n++) @(negedge mclk);
        end
        check(n, exp);
    endtask : rate
    // Trigger reload, both compare modes, rollover, then overflow reload
    task automatic t_reload();
        @(posedge mclk);
        cfg <= '{TCC_TIMER, 1'h0, 1'h1, 1'h1, 1'h1, 4'h2, 4'h0};
        ch_fn <= '{TCC_CH_OFF, TCC_CH_OFF, TCC_CH_CMP, TCC_CH_CMP};
        rld <= 16'hFFFC;
        cmpv <= {32'h0000_0000, 16'hFFFE, 16'hFFFE};
        u_pins.set_pin(1, 1'h0, 1);
        wait_cnt(16'hFFFC, 20);
        @(posedge mclk);
        pwr <= 4'h3;
        pwd <= 4'h3;
        @(posedge mclk);
        pwr <= 4'h0;
        @(negedge mclk);
        check(16'(cmp_pin), 16'h0000);
        wait_cnt(16'hFFFF, 20);
        check(16'(cmp_pin), 16'h0003);
        wait_cnt(16'h0000, 20);
        @(negedge mclk);
        check(16'(cmp_pin), 16'h0002);
        check(16'(ovf_n * 256 + trg_n * 16 + req_n), 16'h0111);
        // Second pass: trigger flag disabled, shadow cleared, mode 0 reload
        @(posedge mclk);
        cfg.external_trigger_enable <= 1'h0;
        pwr <= 4'h2;
        pwd <= 4'h0;
        @(posedge mclk);
        pwr <= 4'h0;
        u_pins.set_pin(1, 1'h1, 12);
        u_pins.set_pin(1, 1'h0, 1);
        wait_cnt(16'hFFFC, 40);
        @(posedge mclk);
        cfg.reload_mode1 <= 1'h0;
        wait_cnt(16'hFFFF, 20);
        check(16'(cmp_pin), 16'h0001);
        wait_cnt(16'hFFFC, 8);
        // Tally runs on this same falling edge; let it settle first
        @(negedge mclk);
        check(16'(ovf_n * 256 + trg_n * 16 + req_n), 16'h0212);
        u_pins.set_pin(1, 1'h1, 1);
    endtask : t_reload
    // Gate low freezes the count, so a capture must read it exactly
    task automatic t_gate_cap();
        logic [15:0] c;
        @(posedge mclk);
        cfg.count_mode <= TCC_GATED;
        cfg.ch_cap_rise <= 4'h4;
        ch_fn[2] <= TCC_CH_CAP;
        u_pins.set_pin(0, 1'h0, 12);
        @(negedge mclk);
        c = count;
        u_pins.set_pin(4, 1'h1, 12);
        u_pins.set_pin(4, 1'h0, 1);
        @(negedge mclk);
        check(count, c);
        check(capv[2], c);
        check(16'(cap_n), 16'h0001);
        u_pins.set_pin(0, 1'h1, 1);
        rate(16'h0006);
        @(posedge mclk);
        cfg.count_mode <= TCC_TIMER;
        cfg.presc_div12 <= 1'h1;
        rate(16'h000C);
    endtask : t_gate_cap
    // Three falling edges, each level held two machine cycles
    task automatic t_event();
        logic [15:0] c;
        @(posedge mclk);
        cfg.count_mode <= TCC_COUNTER;
        cfg.presc_div12 <= 1'h0;
        u_pins.set_pin(0, 1'h1, 12);
        @(negedge mclk);
        c = count;
        repeat (3) begin
            u_pins.set_pin(0, 1'h0, 12);
            u_pins.set_pin(0, 1'h1, 12);
        end
        @(negedge mclk);
        check(count, c + 16'h0003);
    endtask : t_event
    // Reset held three cycles, then the scenarios in turn
    initial begin
        rst_b = 1'h0;
        cfg = '0;
        ch_fn = '{default: TCC_CH_OFF};
        {rld, cmpv, pwr, pwd} = '0;
        {ovf_n, trg_n, req_n, cap_n} = '0;
        repeat (3) @(posedge mclk);
        rst_b <= 1'h1;
        repeat (4) @(posedge mclk);
        t_reload();
        t_gate_cap();
        t_event();
        results();
    end
    // The whole run needs well under a thousand cycles
    initial begin
        #50_000;
        fail_count++;
        results();
    end
endmodule : tcc_top_bench
`default_nettype wire
